// *** hw/sms_regs.vh ***
// Constants of the system-management link supervisor.
`ifndef SMS_REGS_VH
`define SMS_REGS_VH
`define SMS_CLK_HZ        200000000
`define SMS_TICK_CYCLES   28'h0BEB_C200
`define SMS_TICK_W        28
`define SMS_CNT_W         7
`define SMS_T_LOCAL_RST   7'h64
`define SMS_T_PEER_RST    7'h78
`define SMS_T_SUPERVISE   7'h0F
`define SMS_T_RECOVERY    7'h3C
`define SMS_T_FINAL_DELAY 7'h14
`define SMS_T_COLD        7'h5F
`define SMS_T_ONE         7'h01
`define SMS_NLINK         4
`define SMS_L_CTRL        0
`define SMS_L_PSTN        1
`define SMS_L_LINKCTL     2
`define SMS_L_BEARER      3
`endif

// *** hw/sms_tick.v ***
// One-second tick generator derived from the system clock.
`include "sms_regs.vh"
module sms_tick #(
  parameter [`SMS_TICK_W-1:0] TICK_CYCLES = `SMS_TICK_CYCLES
) (
  input  wire clk,
  input  wire rstn,
  input  wire ce,
  output reg  tick
);
  reg [`SMS_TICK_W-1:0] cnt_r;

  // Counts clock cycles and pulses once per period.
  always @(posedge clk) begin
    if (!rstn) begin
      cnt_r <= {`SMS_TICK_W{1'b0}};
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (cnt_r == TICK_CYCLES - 1'b1) begin
        cnt_r <= {`SMS_TICK_W{1'b0}};
        tick  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule // sms_tick

// *** hw/sms_timer.v ***
// Loadable seconds down-counter with a one-cycle expiry pulse.
`include "sms_regs.vh"
module sms_timer (
  input  wire                  clk,
  input  wire                  rstn,
  input  wire                  ce,
  input  wire                  tick,
  input  wire                  start,
  input  wire [`SMS_CNT_W-1:0] load,
  input  wire                  stop,
  output reg                   running,
  output reg                   expired
);
  reg [`SMS_CNT_W-1:0] cnt_r;

  // Start wins over stop; expiry fires on the tick that ends the last second.
  always @(posedge clk) begin
    if (!rstn) begin
      cnt_r   <= {`SMS_CNT_W{1'b0}};
      running <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (start) begin
        cnt_r   <= load;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (cnt_r == `SMS_T_ONE) begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // sms_timer

// *** hw/sms_supervisor.v ***
// Data link supervisor with recovery timer chains and PSTN restart control.
// What this block does
// - Restart acknowledgements arriving while local restart timer idle are discarded.
// - Local restart expiry: maintenance error, restart-complete to control, finish if peer done.
// - Peer restart expiry: maintenance error, restart-complete to PSTN machines, end.
// - Peer restart request ignored while either restart timer runs.
// - Establish indication on an already established link is ignored.
// - Link never established fails on startup protection timer expiry.
// - Established link fails on release, carrier failure or flag failure.
// - A failed link starts its own supervision timer.
// - Failed links keep being re-established, except on carrier or flag loss.
// - Carrier or flag loss stops links; retry after the last condition clears.
// - Re-establishment stops supervision timers; stopped control links get start-traffic.
// - PSTN link down 15 s blocks PSTN ports; restart then unblock.
// - Control link down 15 s: stop-traffic, block ISDN, one-minute timer.
// - Link control down 15 s: stop-traffic to link control, one-minute timer.
// - Bearer link down 15 s starts a one-minute timer.
// - Every timer is accurate to within one second.
// - Local restart timer runs 100 seconds until all acknowledgements arrive.
// - Peer restart timer runs 120 seconds until peer restart-complete.
// - Final startup delay runs 20 s after any recovery expiry, then startup.
// - Cold restart timer runs 95 s from stop or power-up, then startup.
// - PSTN restart sends requests to PSTN machines and starts both timers.
// - All acknowledgements stop local timer, report complete, finish if peer done.
`include "sms_regs.vh"
module sms_supervisor #(
  parameter [`SMS_TICK_W-1:0] TICK_CYCLES = `SMS_TICK_CYCLES
) (
  input  wire                    CLK,
  input  wire                    RSTN,
  input  wire                    CE,
  input  wire [`SMS_NLINK-1:0]   LINK_ESTABLISH_IND,
  input  wire [`SMS_NLINK-1:0]   LINK_ESTABLISH_CNF,
  input  wire [`SMS_NLINK-1:0]   LINK_RELEASE_IND,
  input  wire [`SMS_NLINK-1:0]   CARRIER_FAIL,
  input  wire [`SMS_NLINK-1:0]   FLAG_FAIL,
  input  wire                    STARTUP_PROT_END,
  input  wire                    IF_STOP,
  input  wire                    CTRL_RESTART_REQ,
  input  wire                    CTRL_RESTART_CMPL,
  input  wire                    PSTN_RESTART_ACK_ALL,
  output reg  [`SMS_NLINK-1:0]   LINK_ESTABLISHED,
  output reg  [`SMS_NLINK-1:0]   LINK_ESTABLISH_REQ,
  output reg  [`SMS_NLINK-1:0]   CARRIER_FAIL_IND,
  output reg                     CTRL_TRAFFIC_START,
  output reg                     LINKCTL_TRAFFIC_START,
  output reg                     CTRL_TRAFFIC_STOP,
  output reg                     LINKCTL_TRAFFIC_STOP,
  output reg                     ISDN_PORTS_BLOCK,
  output reg                     PSTN_PORTS_BLOCK,
  output reg                     PSTN_PORTS_UNBLOCK,
  output reg                     PSTN_RESTART_REQ,
  output reg                     CTRL_RESTART_REQ_OUT,
  output reg                     CTRL_RESTART_CMPL_OUT,
  output reg                     PSTN_RESTART_CMPL,
  output reg                     MAINT_ERROR,
  output reg                     SYSTEM_STARTUP
);
  // Restart procedure states.
  localparam [1:0] RS_IDLE = 2'b00;
  localparam [1:0] RS_BUSY = 2'b01;

  // How the pieces fit together.
  // Every timer below is one sms_timer instance that counts whole seconds.
  // All of them share a single one-second tick, so they age in step.
  // A timer start in the same cycle as its stop is taken as a start.
  // Expiry is a one-cycle pulse, and the outputs follow one edge later.
  // Link state is kept per link as bit vectors, indexed by the link number.
  // Bit 0 is the common control link and bit 1 the PSTN signalling link.
  // Bit 2 is the link management link and bit 3 the bearer allocation link.
  // A link counts as failed from its failure until it is established again.
  // Establish requests stand as levels while a link is failed.
  // Carrier or flag loss masks those requests for as long as it lasts.
  // The supervision timer of a link guards its first fifteen seconds down.
  // Its expiry raises the link's own reaction, which differs per link.
  // Links other than the PSTN link then run a one-minute recovery timer.
  // A recovery expiry starts the final startup delay, which is never stopped.
  // The final delay is not started again while it is already running.
  // The cold restart timer runs from power-up and from an interface stop.
  // The restart procedure has two states, idle and busy.
  // It leaves busy when both sides are closed or the peer timer runs out.
  // A side is closed by its completion or, locally, by the timer expiry.
  // Closed sides are remembered until the procedure returns to idle.
  // A peer request while either restart timer runs is dropped silently.
  // Late acknowledgements after the local timer stopped are dropped too.
  // The PSTN ports are unblocked only if a blocking came before.
  // Each supervision timer is stopped by any new establish of its link.
  // The recovery timer of a link is stopped the same way.
  // The PSTN link has no recovery stage; its expiry blocks the ports.
  // Traffic start is sent only to control protocols that were stopped.
  // Stop flags are set by a supervision expiry and cleared by an establish.
  // A failure before the first establish shows only at protection end.
  // That path covers links that never came up since startup.
  // An establish on an already established link changes nothing.
  // Every output is a flip-flop, so each reaction is one edge late.
  // Counters are sized for the longest timeout, the peer restart.
  // The tick divider is a parameter so that benches can shorten time.
  // A real system uses the full clock rate as the divider.
  // Hazard: the clock enable freezes timers and tick alike, so time stalls.

  // Status of the timer instances.
  wire                  tick;
  wire                  t_loc_run;
  wire                  t_loc_exp;
  wire                  t_peer_run;
  wire                  t_peer_exp;
  wire [`SMS_NLINK-1:0] sup_run;
  wire [`SMS_NLINK-1:0] sup_exp;
  wire [`SMS_NLINK-1:0] rec_run;
  wire [`SMS_NLINK-1:0] rec_exp;
  wire                  fin_run;
  wire                  fin_exp;
  wire                  cold_run;
  wire                  cold_exp;

  // State kept by the processes below.
  reg  [1:0]            rs_state_r;
  reg                   peer_done_r;
  reg                   local_done_r;
  reg                   pstn_blocked_r;
  reg  [`SMS_NLINK-1:0] failed_r;
  reg  [`SMS_NLINK-1:0] ever_up_r;
  reg                   ctrl_stopped_r;
  reg                   linkctl_stopped_r;
  reg                   power_up_r;

  // Any establish event, and any layer-one loss, per link.
  wire [`SMS_NLINK-1:0] est_any = LINK_ESTABLISH_IND | LINK_ESTABLISH_CNF;
  wire [`SMS_NLINK-1:0] l1_bad  = CARRIER_FAIL | FLAG_FAIL;
  // New arrivals only: establish on an already established link does nothing.
  wire [`SMS_NLINK-1:0] est_new = est_any & ~LINK_ESTABLISHED;
  // Failure of an established link, or of one never up at protection end.
  wire [`SMS_NLINK-1:0] fail_ev =
    (LINK_ESTABLISHED & (LINK_RELEASE_IND | l1_bad)) |
    ({`SMS_NLINK{STARTUP_PROT_END}} & ~ever_up_r & ~LINK_ESTABLISHED);
  // A PSTN link coming back after a failure starts a restart.
  wire pstn_up_after_fail = est_new[`SMS_L_PSTN] & failed_r[`SMS_L_PSTN];
  wire restart_idle       = (rs_state_r == RS_IDLE);
  // Peer request only accepted with both restart timers idle.
  wire peer_req_ok = CTRL_RESTART_REQ && !t_loc_run && !t_peer_run;
  wire start_restart      = restart_idle && (pstn_up_after_fail || peer_req_ok);
  // Acks only count while the local restart timer runs.
  wire ack_ok      = PSTN_RESTART_ACK_ALL && t_loc_run;
  wire peer_cmpl   = CTRL_RESTART_CMPL && t_peer_run;
  // Each side of the restart is closed by completion; the local side also by expiry.
  wire loc_closed  = ack_ok || t_loc_exp || local_done_r;
  wire peer_closed = peer_cmpl || peer_done_r;
  wire finish      = !restart_idle && (t_peer_exp || (loc_closed && peer_closed));

  sms_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .clk  (CLK),
    .rstn (RSTN),
    .ce   (CE),
    .tick (tick)
  );

  // Restart timers: 100 s local, 120 s peer.
  sms_timer u_loc (
    .clk     (CLK),
    .rstn    (RSTN),
    .ce      (CE),
    .tick    (tick),
    .start   (start_restart),
    .load    (`SMS_T_LOCAL_RST),
    .stop    (ack_ok),
    .running (t_loc_run),
    .expired (t_loc_exp)
  );
  sms_timer u_peer (
    .clk     (CLK),
    .rstn    (RSTN),
    .ce      (CE),
    .tick    (tick),
    .start   (start_restart),
    .load    (`SMS_T_PEER_RST),
    .stop    (peer_cmpl),
    .running (t_peer_run),
    .expired (t_peer_exp)
  );

  // Per-link 15 s supervision and one-minute recovery timers.
  genvar g;
  generate
    for (g = 0; g < `SMS_NLINK; g = g + 1) begin : g_link
      sms_timer u_sup (
        .clk     (CLK),
        .rstn    (RSTN),
        .ce      (CE),
        .tick    (tick),
        .start   (fail_ev[g]),
        .load    (`SMS_T_SUPERVISE),
        .stop    (est_new[g]),
        .running (sup_run[g]),
        .expired (sup_exp[g])
      );
      // The PSTN link has no recovery stage; its timer is never started.
      sms_timer u_rec (
        .clk     (CLK),
        .rstn    (RSTN),
        .ce      (CE),
        .tick    (tick),
        .start   (sup_exp[g] && (g != `SMS_L_PSTN)),
        .load    (`SMS_T_RECOVERY),
        .stop    (est_new[g]),
        .running (rec_run[g]),
        .expired (rec_exp[g])
      );
    end
  endgenerate

  // Final startup delay: 20 s after any recovery expiry, never stopped.
  sms_timer u_fin (
    .clk     (CLK),
    .rstn    (RSTN),
    .ce      (CE),
    .tick    (tick),
    .start   (|rec_exp && !fin_run),
    .load    (`SMS_T_FINAL_DELAY),
    .stop    (1'b0),
    .running (fin_run),
    .expired (fin_exp)
  );
  // Cold restart: 95 s after power-up or interface stop, never stopped.
  sms_timer u_cold (
    .clk     (CLK),
    .rstn    (RSTN),
    .ce      (CE),
    .tick    (tick),
    .start   (power_up_r || (IF_STOP && !cold_run)),
    .load    (`SMS_T_COLD),
    .stop    (1'b0),
    .running (cold_run),
    .expired (cold_exp)
  );

  // Next value of a set-dominant flag: the set event wins over the clear.
  function flag_nxt;
    input set_ev;
    input cur;
    input clr_ev;
    begin
      flag_nxt = set_ev || (cur && !clr_ev);
    end
  endfunction

  // Link condition tracking and re-establishment requests.
  // Requests are registered, so they follow the failure by one edge.
  always @(posedge CLK) begin
    if (!RSTN) begin
      LINK_ESTABLISHED   <= {`SMS_NLINK{1'b0}};
      LINK_ESTABLISH_REQ <= {`SMS_NLINK{1'b0}};
      CARRIER_FAIL_IND   <= {`SMS_NLINK{1'b0}};
      failed_r           <= {`SMS_NLINK{1'b0}};
      ever_up_r          <= {`SMS_NLINK{1'b0}};
      power_up_r         <= 1'b1;
    end else if (CE) begin
      power_up_r       <= 1'b0;
      LINK_ESTABLISHED <= (LINK_ESTABLISHED | est_new) & ~fail_ev;
      ever_up_r        <= ever_up_r | est_new;
      failed_r         <= (failed_r | fail_ev) & ~est_new;
      CARRIER_FAIL_IND <= fail_ev & l1_bad;
      // Keep asking for failed links unless held by layer-one loss.
      LINK_ESTABLISH_REQ <= (failed_r | fail_ev) & ~est_new & ~l1_bad;
    end
  end

  // Traffic control, port blocking and startup outputs.
  // Reactions to a supervision expiry come one edge after it.
  always @(posedge CLK) begin
    if (!RSTN) begin
      CTRL_TRAFFIC_START    <= 1'b0;
      LINKCTL_TRAFFIC_START <= 1'b0;
      CTRL_TRAFFIC_STOP     <= 1'b0;
      LINKCTL_TRAFFIC_STOP  <= 1'b0;
      ISDN_PORTS_BLOCK      <= 1'b0;
      PSTN_PORTS_BLOCK      <= 1'b0;
      SYSTEM_STARTUP        <= 1'b0;
      ctrl_stopped_r        <= 1'b0;
      linkctl_stopped_r     <= 1'b0;
      pstn_blocked_r        <= 1'b0;
    end else if (CE) begin
      CTRL_TRAFFIC_STOP    <= sup_exp[`SMS_L_CTRL];
      ISDN_PORTS_BLOCK     <= sup_exp[`SMS_L_CTRL];
      LINKCTL_TRAFFIC_STOP <= sup_exp[`SMS_L_LINKCTL];
      PSTN_PORTS_BLOCK     <= sup_exp[`SMS_L_PSTN];
      CTRL_TRAFFIC_START    <= est_new[`SMS_L_CTRL] &&
                               (ctrl_stopped_r || sup_exp[`SMS_L_CTRL]);
      LINKCTL_TRAFFIC_START <= est_new[`SMS_L_LINKCTL] &&
                               (linkctl_stopped_r || sup_exp[`SMS_L_LINKCTL]);
      // Stop flag is set by the supervision expiry; set wins over clear.
      ctrl_stopped_r    <= flag_nxt(sup_exp[`SMS_L_CTRL], ctrl_stopped_r,
                                    est_new[`SMS_L_CTRL]);
      linkctl_stopped_r <= flag_nxt(sup_exp[`SMS_L_LINKCTL], linkctl_stopped_r,
                                    est_new[`SMS_L_LINKCTL]);
      pstn_blocked_r    <= flag_nxt(sup_exp[`SMS_L_PSTN], pstn_blocked_r, finish);
      SYSTEM_STARTUP    <= fin_exp || cold_exp;
    end
  end

  // PSTN restart procedure.
  always @(posedge CLK) begin
    if (!RSTN) begin
      rs_state_r            <= RS_IDLE;
      peer_done_r           <= 1'b0;
      local_done_r          <= 1'b0;
      PSTN_RESTART_REQ      <= 1'b0;
      CTRL_RESTART_REQ_OUT  <= 1'b0;
      CTRL_RESTART_CMPL_OUT <= 1'b0;
      PSTN_RESTART_CMPL     <= 1'b0;
      MAINT_ERROR           <= 1'b0;
      PSTN_PORTS_UNBLOCK    <= 1'b0;
    end else if (CE) begin
      PSTN_RESTART_REQ      <= start_restart;
      CTRL_RESTART_REQ_OUT  <= start_restart && pstn_up_after_fail;
      CTRL_RESTART_CMPL_OUT <= !restart_idle && (ack_ok || t_loc_exp);
      MAINT_ERROR           <= !restart_idle && (t_loc_exp || t_peer_exp);
      PSTN_RESTART_CMPL     <= finish;
      PSTN_PORTS_UNBLOCK    <= finish && pstn_blocked_r;
      // Done flags clear in idle and collect closures while busy.
      case (rs_state_r)
        RS_IDLE: begin
          peer_done_r  <= 1'b0;
          local_done_r <= 1'b0;
          if (start_restart) begin
            rs_state_r <= RS_BUSY;
          end
        end
        RS_BUSY: begin
          peer_done_r  <= peer_closed;
          local_done_r <= loc_closed;
          if (finish) begin
            rs_state_r <= RS_IDLE;
          end
        end
        default: begin
          rs_state_r <= RS_IDLE;
        end
      endcase
    end
  end
endmodule // sms_supervisor

// *** bench/sms_sup_chk_sva.sv ***
// Port-level checker of the link supervisor, bound into the design.
module sms_sup_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire       CLK,
  input wire       RSTN,
  input wire [3:0] LINK_ESTABLISH_IND,
  input wire [3:0] LINK_ESTABLISH_CNF,
  input wire [3:0] LINK_RELEASE_IND,
  input wire [3:0] CARRIER_FAIL,
  input wire [3:0] LINK_ESTABLISHED,
  input wire [3:0] LINK_ESTABLISH_REQ,
  input wire [3:0] CARRIER_FAIL_IND,
  input wire       CTRL_TRAFFIC_START,
  input wire       CTRL_TRAFFIC_STOP,
  input wire       ISDN_PORTS_BLOCK,
  input wire       CTRL_RESTART_REQ_OUT,
  input wire       PSTN_RESTART_REQ,
  input wire       MAINT_ERROR,
  input wire       CTRL_RESTART_CMPL_OUT,
  input wire       PSTN_RESTART_CMPL,
  input wire       SYSTEM_STARTUP
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] cyc_r;
  // Cycles since reset release give the earliest legal startup.
  always @(posedge CLK) begin
    if (!RSTN) cyc_r <= 32'h0000_0000;
    else if (cyc_r != 32'hFFFF_FFFF) cyc_r <= cyc_r + 32'h0000_0001;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_EST_SET: assert property (LINK_ESTABLISH_IND[1] && !LINK_RELEASE_IND[1] &&
    !CARRIER_FAIL[1] |=> LINK_ESTABLISHED[1]) else $error("establish not held");
  AST_REL_FAIL: assert property (LINK_ESTABLISHED[1] && LINK_RELEASE_IND[1] &&
    !LINK_ESTABLISH_IND[1] && !LINK_ESTABLISH_CNF[1] |=> !LINK_ESTABLISHED[1] &&
    LINK_ESTABLISH_REQ[1]) else $error("release not taken as failure");
  AST_REQ_CLEAR: assert property (LINK_ESTABLISH_CNF[0] && !CARRIER_FAIL[0] &&
    !LINK_RELEASE_IND[0] |=> LINK_ESTABLISHED[0] && !LINK_ESTABLISH_REQ[0])
    else $error("confirm did not end retries");
  AST_L1_IND: assert property ($rose(CARRIER_FAIL[0]) && LINK_ESTABLISHED[0]
    |=> CARRIER_FAIL_IND[0] ##1 !CARRIER_FAIL_IND[0]) else $error("carrier indication");
  AST_L1_HOLD: assert property (CARRIER_FAIL[0] |=> !LINK_ESTABLISH_REQ[0])
    else $error("retry during carrier loss");
  AST_TSTART: assert property (CTRL_TRAFFIC_START |->
    $past(LINK_ESTABLISH_IND[0] | LINK_ESTABLISH_CNF[0])) else $error("stray start");
  AST_ISDN: assert property (ISDN_PORTS_BLOCK |-> CTRL_TRAFFIC_STOP &&
    !LINK_ESTABLISHED[0]) else $error("block without stop");
  AST_RREQ: assert property (CTRL_RESTART_REQ_OUT |-> PSTN_RESTART_REQ)
    else $error("restart request not sent to machines");
  AST_MAINT: assert property (MAINT_ERROR |-> CTRL_RESTART_CMPL_OUT ||
    PSTN_RESTART_CMPL) else $error("error without completion");
  AST_START: assert property (SYSTEM_STARTUP |-> cyc_r >= 93 * TICK_CYCLES)
    else $error("startup too early");
endmodule // sms_sup_chk

bind sms_supervisor sms_sup_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// *** bench/sms_link_peer.sv ***
// Behavioural data links and PSTN machines facing the supervisor.
module sms_link_peer (
  input  wire        clk,
  input  wire        rstn,
  input  wire  [3:0] req,
  input  wire  [3:0] link_en,
  output logic [3:0] cnf,
  input  wire        rst_req,
  input  wire        ack_en,
  input  wire        poke,
  output logic       ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] wait_r [4];
  logic [2:0] ack_r;
  // Enabled links confirm after four cycles of request; machines ack four cycles late.
  always @(posedge clk) begin
    cnf <= 4'h0;
    ack <= poke;
    if (!rstn) begin
      ack_r <= 3'h0;
      for (int i = 0; i < 4; i++) wait_r[i] <= 3'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!(req[i] && link_en[i])) wait_r[i] <= 3'h0;
        else if (wait_r[i] != 3'h7) wait_r[i] <= wait_r[i] + 3'h1;
        if (req[i] && link_en[i] && wait_r[i] == 3'h3) cnf[i] <= 1'b1;
      end
      if (rst_req && ack_en) ack_r <= 3'h4;
      else if (ack_r != 3'h0) ack_r <= ack_r - 3'h1;
      if (ack_r == 3'h1) ack <= 1'b1;
    end
  end
endmodule // sms_link_peer

// *** bench/test_sms_supervisor.sv ***
// Self-checking bench of the link supervisor.
module test_sms_supervisor;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 4;
  logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, stop_if = 1'b0, prot_end = 1'b0;
  logic rreq = 1'b0, rcmpl = 1'b0, poke = 1'b0, ack_en = 1'b0;
  logic [3:0] ind = 4'h0, rel = 4'h0, car = 4'h0, flag = 4'h0, lk_en = 4'h0;
  wire [3:0] cnf, est, ereq, l1;
  wire ack, ts_c, tp_c, tp_l, blk_i, blk_p, unb_p, prq, crq, cco, pco, merr, sup;
  int n_fail = 0, samples_checked = 0;
  int ev [13];
  wire [12:0] pv = {l1[0], ts_c, tp_l, tp_c, blk_i, sup, merr, pco, cco, crq, prq, unb_p, blk_p};
  always #2.5 clk = ~clk;
  // Pulse counters of the event outputs, indexed from the right of pv.
  always @(posedge clk) for (int k = 0; k < 13; k++) if (pv[k] === 1'b1) ev[k] <= ev[k] + 1;
  sms_supervisor #(.TICK_CYCLES(TK[27:0])) dut (
    .CLK(clk), .RSTN(rstn), .CE(ce), .LINK_ESTABLISH_IND(ind), .LINK_ESTABLISH_CNF(cnf),
    .LINK_RELEASE_IND(rel), .CARRIER_FAIL(car), .FLAG_FAIL(flag), .STARTUP_PROT_END(prot_end),
    .IF_STOP(stop_if), .CTRL_RESTART_REQ(rreq), .CTRL_RESTART_CMPL(rcmpl),
    .PSTN_RESTART_ACK_ALL(ack), .LINK_ESTABLISHED(est), .LINK_ESTABLISH_REQ(ereq),
    .CARRIER_FAIL_IND(l1), .CTRL_TRAFFIC_START(ts_c), .LINKCTL_TRAFFIC_START(),
    .CTRL_TRAFFIC_STOP(tp_c), .LINKCTL_TRAFFIC_STOP(tp_l), .ISDN_PORTS_BLOCK(blk_i),
    .PSTN_PORTS_BLOCK(blk_p), .PSTN_PORTS_UNBLOCK(unb_p), .PSTN_RESTART_REQ(prq),
    .CTRL_RESTART_REQ_OUT(crq), .CTRL_RESTART_CMPL_OUT(cco), .PSTN_RESTART_CMPL(pco),
    .MAINT_ERROR(merr), .SYSTEM_STARTUP(sup));
  sms_link_peer u_peer (.clk(clk), .rstn(rstn), .req(ereq), .link_en(lk_en), .cnf(cnf),
    .rst_req(prq), .ack_en(ack_en), .poke(poke), .ack(ack));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Waits for event k and checks it came about s seconds later.
  task automatic wait_ev(input int k, input int s);
    int n0, c;
    #1;
    n0 = ev[k];
    c = 0;
    while (ev[k] == n0 && c < (s + 2) * TK + 9) begin
      @(posedge clk);
      #1;
      c++;
    end
    check(ev[k] != n0 && c >= (s - 1) * TK - 8, 1);
  endtask
  task automatic s_est();
    // An establish while the clock enable is low must leave no trace.
    @(posedge clk) ce <= 1'b0;
    ind <= 4'h8;
    @(posedge clk) ind <= 4'h0;
    ce <= 1'b1;
    @(posedge clk) ind <= 4'h3;
    @(posedge clk) ind <= 4'h2;
    @(posedge clk) ind <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
    check({est, ereq[1:0]}, 6'h0C);
  endtask
  task automatic s_pstn();
    int r0, p0;
    r0 = ev[3];
    p0 = ev[5];
    @(posedge clk) rel <= 4'h2;
    @(posedge clk) rel <= 4'h0;
    wait_ev(0, 15);
    @(posedge clk) lk_en <= 4'h2;
    ack_en <= 1'b1;
    wait_ev(2, 0);
    wait_ev(4, 0);
    check(ev[3] - r0, 1);
    @(posedge clk) rcmpl <= 1'b1;
    @(posedge clk) rcmpl <= 1'b0;
    wait_ev(1, 0);
    repeat (3) @(posedge clk);
    #1;
    check({ev[5] - p0, est[1]}, 3);
  endtask
  task automatic s_rst();
    int c0, p0, q0;
    @(posedge clk) ack_en <= 1'b0;
    c0 = ev[4];
    p0 = ev[5];
    q0 = ev[2];
    poke <= 1'b1;
    @(posedge clk) poke <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check(ev[4], c0);
    @(posedge clk) rreq <= 1'b1;
    @(posedge clk) rreq <= 1'b0;
    @(posedge clk) rreq <= 1'b1;
    @(posedge clk) rreq <= 1'b0;
    wait_ev(6, 100);
    check({ev[4] - c0, ev[5] - p0}, 64'h1_0000_0000);
    wait_ev(6, 20);
    check({ev[5] - p0, ev[2] - q0}, 64'h1_0000_0001);
  endtask
  task automatic s_l1();
    int t0;
    t0 = ev[9];
    @(posedge clk) lk_en <= 4'h3;
    car <= 4'h1;
    wait_ev(12, 0);
    check(ereq[0], 1'b0);
    wait_ev(8, 15);
    check(ev[9] - t0, 1);
    @(posedge clk) car <= 4'h0;
    wait_ev(11, 0);
    check(est[0], 1'b1);
    @(posedge clk) flag <= 4'h1;
    wait_ev(12, 0);
    check(ereq[0], 1'b0);
    @(posedge clk) flag <= 4'h0;
    repeat (8) @(posedge clk);
    #1;
    check(est[0], 1'b1);
  endtask
  task automatic s_prot();
    @(posedge clk) prot_end <= 1'b1;
    @(posedge clk) prot_end <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(ereq[3:2], 2'h3);
    wait_ev(10, 15);
    wait_ev(7, 80);
    @(posedge clk) stop_if <= 1'b1;
    @(posedge clk) stop_if <= 1'b0;
    wait_ev(7, 95);
  endtask
  // Watchdog well beyond the expected run of about two thousand cycles.
  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  // Main sequence: reset for two cycles, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wait_ev(7, 95);
    s_est();
    s_pstn();
    s_rst();
    s_l1();
    s_prot();
    stop_test();
  end
endmodule // test_sms_supervisor
